//--- dv/ccr_bank_bench.sv
// self-checking bench for the charger control register bank
`timescale 1ns/1ps
module ccr_bank_bench;
  import ccr_pkg::*;
  // short counts keep the run brief; the ship and wake expectations use these
  localparam logic [31:0] SHIP_CYC = 32'd20;
  localparam logic [31:0] WL_CYC = 32'd30;
  localparam logic [31:0] WS_CYC = 32'd10;
  logic clk_sys, rst, reg_wr, reg_soft_reset, watchdog_expire, config_strap_pin, on_request_pin;
  logic pair_one_abs, pair_two_abs;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v, r, e13;
  logic ship_action_fire, ship_wake_req;
  logic [1:0] ship_action_code;
  logic [13:0] flags;
  logic [31:0] rnd;
  int n_mismatch, compares;

  ccr_bank #(.SHIP_DELAY_CYC(SHIP_CYC), .WAKE_LONG_CYC(WL_CYC), .WAKE_SHORT_CYC(WS_CYC)) u_ccr_bank (
    .clk_sys(clk_sys), .rst(rst), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_soft_reset(reg_soft_reset),
    .watchdog_expire(watchdog_expire), .fet_pair_one_absent(pair_one_abs),
    .fet_pair_two_absent(pair_two_abs),
    .config_strap_pin(config_strap_pin), .on_request_pin(on_request_pin),
    .ship_action_fire(ship_action_fire), .ship_action_code(ship_action_code),
    .ship_wake_req(ship_wake_req), .input_driver_master_disable(flags[13]),
    .reverse_output_enable(flags[12]), .reverse_pulse_freq_disable(flags[11]),
    .forward_pulse_freq_disable(flags[10]), .ship_wake_pulse_select(flags[9]),
    .batt_switch_linear_disable(flags[8]), .reverse_out_of_audio_disable(flags[7]),
    .forward_out_of_audio_disable(flags[6]), .input_gate_driver_two_enable(flags[5]),
    .input_gate_driver_one_enable(flags[4]), .switching_frequency_select(flags[3]),
    .status_pin_disable(flags[2]), .system_short_hiccup_disable(flags[1]),
    .reverse_undervoltage_hiccup_disable(flags[0])
  );

  ccr_host_model u_ccr_host_model (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ship_wake_req(ship_wake_req), .on_request_pin(on_request_pin)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction

  // pair two is absent here, and master disable forces both enables low
  function automatic logic [7:0] lock13(input logic [7:0] d, input logic [7:0] c3);
    return d & 8'h7f & (c3[7] ? 8'h3f : 8'hff);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_ccr_host_model.rd(a, d);
    check(what, 32'(d), 32'(e));
  endtask

  task automatic pulse(input bit wd);
    @(negedge clk_sys);
    if (wd) begin
      watchdog_expire = 1'b1;
    end else begin
      reg_soft_reset = 1'b1;
    end
    @(negedge clk_sys);
    watchdog_expire = 1'b0;
    reg_soft_reset = 1'b0;
  endtask

  task automatic ship(input logic [1:0] code, input logic skip);
    int n;
    n = 0;
    u_ccr_host_model.wr(CCR_OFS_CTRL_TWO, {5'h00, code, skip});
    while (n < 100 && ship_action_fire !== 1'b1) begin
      @(posedge clk_sys);
      n++;
      @(negedge clk_sys);
    end
    check("ship_wait", 32'(n), skip ? 32'd0 : SHIP_CYC);
    check("ship_code", 32'(ship_action_code), 32'(code));
    rc("ctrl_two", CCR_OFS_CTRL_TWO, {7'h00, skip});
  endtask

  task automatic wake(input logic sel, input logic [31:0] w);
    int n;
    u_ccr_host_model.wr(CCR_OFS_CTRL_THREE, {4'h0, sel, 3'h0});
    u_ccr_host_model.hold_pin(200, n);
    check("wake_hold", 32'(n >= int'(w) && n <= int'(w) + 8), 32'd1);
    $display("wake test done, select %b", sel);
  endtask

  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    rst = 1'b1;
    reg_soft_reset = 1'b0;
    watchdog_expire = 1'b0;
    config_strap_pin = 1'b1;
    pair_one_abs = 1'b0;
    pair_two_abs = 1'b1;
    rnd = 32'd82;
    n_mismatch = 0;
    compares = 0;
    e13 = 8'h00;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    rc("ctrl_three_rst", CCR_OFS_CTRL_THREE, CCR_RST_CTRL_THREE);
    rc("ctrl_four_rst", CCR_OFS_CTRL_FOUR, 8'h21);
    rc("ctrl_two_rst", CCR_OFS_CTRL_TWO, 8'h00);
    check("flags_rst", 32'(flags), 32'h0008);
    u_ccr_host_model.wr(8'h14, 8'hff);
    rc("unmapped", 8'h14, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : xs() & 8'hff;
      r = (i < 2) ? 8'hff : xs() & 8'hff;
      u_ccr_host_model.wr(CCR_OFS_CTRL_THREE, v);
      rc("ctrl_three", CCR_OFS_CTRL_THREE, v);
      u_ccr_host_model.wr(CCR_OFS_CTRL_FOUR, r);
      e13 = lock13(r, v);
      rc("ctrl_four", CCR_OFS_CTRL_FOUR, e13);
      check("flags", 32'(flags), 32'({v, e13[7:2]}));
      // watchdog lapse stands in for a missed kick
      pulse(1'b1);
      rc("ctrl_three_wd", CCR_OFS_CTRL_THREE, v & 8'h99);
      e13 = e13 & 8'hef;
      rc("ctrl_four_wd", CCR_OFS_CTRL_FOUR, e13);
    end
    $display("register test done");
    pulse(1'b0);
    rc("ctrl_three_soft", CCR_OFS_CTRL_THREE, 8'h00);
    rc("ctrl_four_soft", CCR_OFS_CTRL_FOUR, 8'h01 | (e13 & 8'h20));
    $display("soft reset test done");
    for (int c = 1; c < 4; c++) begin
      ship(2'(c), 1'b1);
    end
    ship(CCR_ACT_SHIP, 1'b0);
    $display("ship test done");
    wake(1'b0, WL_CYC);
    wake(1'b1, WS_CYC);
    // second power-up in mid-run: the other pair is missing and the strap is low
    @(negedge clk_sys);
    rst = 1'b1;
    pair_one_abs = 1'b1;
    pair_two_abs = 1'b0;
    config_strap_pin = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (6) @(negedge clk_sys);
    rc("ctrl_four_rst2", CCR_OFS_CTRL_FOUR, 8'h01);
    u_ccr_host_model.wr(CCR_OFS_CTRL_FOUR, 8'hff);
    rc("ctrl_four_lock1", CCR_OFS_CTRL_FOUR, 8'hbf);
    check("drv_two_on", 32'(flags[5]), 32'd1);
    $display("second reset test done");
    end_sim();
  end
endmodule // ccr_bank_bench

//--- dv/ccr_host_model.sv
// host-side model: byte register accesses and the on-request pin
`timescale 1ns/1ps
module ccr_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic ship_wake_req,
  output logic on_request_pin
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    on_request_pin = 1'b1;
  end

  // one write per strobe; data is scrambled once the strobe drops so stale bytes are not reused
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask

  // read data is registered, so it is taken one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task automatic hold_pin(input int limit, output int n);
    n = 0;
    @(negedge clk_sys);
    on_request_pin = 1'b0;
    while (n < limit && ship_wake_req !== 1'b1) begin
      @(negedge clk_sys);
      n++;
    end
    on_request_pin = 1'b1;
  endtask
endmodule // ccr_host_model

//--- verilog/ccr_bank.sv
// charger control register bank: three byte registers, ship switch sequencer, wake timer
`timescale 1ns/1ps
module ccr_bank
  import ccr_pkg::*;
#(
  parameter logic [31:0] SHIP_DELAY_CYC = CCR_SHIP_DELAY_CYC,
  parameter logic [31:0] WAKE_LONG_CYC = CCR_WAKE_LONG_CYC,
  parameter logic [31:0] WAKE_SHORT_CYC = CCR_WAKE_SHORT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic reg_soft_reset,
  input wire logic watchdog_expire,
  input wire logic fet_pair_one_absent,
  input wire logic fet_pair_two_absent,
  input wire logic config_strap_pin,
  input wire logic on_request_pin,
  output logic ship_action_fire,
  output logic [1:0] ship_action_code,
  output logic ship_wake_req,
  output logic input_driver_master_disable,
  output logic reverse_output_enable,
  output logic reverse_pulse_freq_disable,
  output logic forward_pulse_freq_disable,
  output logic ship_wake_pulse_select,
  output logic batt_switch_linear_disable,
  output logic reverse_out_of_audio_disable,
  output logic forward_out_of_audio_disable,
  output logic input_gate_driver_two_enable,
  output logic input_gate_driver_one_enable,
  output logic switching_frequency_select,
  output logic status_pin_disable,
  output logic system_short_hiccup_disable,
  output logic reverse_undervoltage_hiccup_disable
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction
  logic wr_two, wr_three, wr_four;
  assign wr_two = clk_en && reg_wr && hit(reg_addr, CCR_OFS_CTRL_TWO);
  assign wr_three = clk_en && reg_wr && hit(reg_addr, CCR_OFS_CTRL_THREE);
  assign wr_four = clk_en && reg_wr && hit(reg_addr, CCR_OFS_CTRL_FOUR);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] strap_sync_q, onreq_sync_q;
  logic strap_stable_q, onreq_stable_q, strap_settled;
  // third stage agreeing with second marks a settled level
  assign strap_settled = (strap_sync_q[1] == strap_sync_q[2]) ? strap_sync_q[2] : strap_stable_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_sync_q <= 3'h0;
      onreq_sync_q <= 3'h7;
      strap_stable_q <= 1'b0;
      onreq_stable_q <= 1'b1;
    end else if (clk_en) begin
      strap_sync_q <= {strap_sync_q[1:0], config_strap_pin};
      onreq_sync_q <= {onreq_sync_q[1:0], on_request_pin};
      strap_stable_q <= strap_settled;
      if (onreq_sync_q[1] == onreq_sync_q[2]) begin
        onreq_stable_q <= onreq_sync_q[2];
      end
    end
  end

  // ---------------------------------------------------------------
  // power-on capture of strap and pair presence
  // ---------------------------------------------------------------
  logic [1:0] settle_cnt_q;
  logic settle_done_q, pair_one_absent_q, pair_two_absent_q, strap_load;
  assign strap_load = clk_en && !settle_done_q && (settle_cnt_q == CCR_STRAP_SETTLE_CYC);
  // captured after release so the strap has crossed the synchroniser
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      settle_cnt_q <= 2'h0;
      settle_done_q <= 1'b0;
      pair_one_absent_q <= 1'b0;
      pair_two_absent_q <= 1'b0;
    end else if (clk_en && !settle_done_q) begin
      settle_cnt_q <= settle_cnt_q + 2'h1;
      if (strap_load) begin
        settle_done_q <= 1'b1;
        pair_one_absent_q <= fet_pair_one_absent;
        pair_two_absent_q <= fet_pair_two_absent;
      end
    end
  end

  // ---------------------------------------------------------------
  // control three
  // ---------------------------------------------------------------
  logic [7:0] three_q;
  always_ff @(posedge clk_sys) begin
    if (rst || (clk_en && reg_soft_reset)) begin
      three_q <= CCR_RST_CTRL_THREE;
    end else if (wr_three) begin
      three_q <= reg_wdata;
    end else if (clk_en && watchdog_expire) begin
      three_q[CCR_B3_REV_OUT_EN] <= 1'b0;
      three_q[CCR_B3_REV_PFM_DIS] <= 1'b0;
      three_q[CCR_B3_LIN_DIS] <= 1'b0;
      three_q[CCR_B3_REV_OOA_DIS] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control four
  // ---------------------------------------------------------------
  logic drv_two_q, drv_one_q, freq_q, master_dis_next;
  logic [4:0] four_lo_q;
  assign master_dis_next = wr_three ? reg_wdata[CCR_B3_DRV_MASTER_DIS]
                                    : three_q[CCR_B3_DRV_MASTER_DIS];
  always_ff @(posedge clk_sys) begin
    if (rst || (clk_en && reg_soft_reset)) begin
      drv_two_q <= 1'b0;
      drv_one_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_four) begin
        drv_two_q <= reg_wdata[CCR_B4_DRV_TWO_EN];
        drv_one_q <= reg_wdata[CCR_B4_DRV_ONE_EN];
      end
      if (master_dis_next || pair_two_absent_q || (strap_load && fet_pair_two_absent)) begin
        drv_two_q <= 1'b0;
      end
      if (master_dis_next || pair_one_absent_q || (strap_load && fet_pair_one_absent)) begin
        drv_one_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freq_q <= 1'b0;
    end else if (strap_load) begin
      // take the level settling at this edge; the settled flop would be one edge late
      freq_q <= strap_settled;
    end else if (wr_four) begin
      freq_q <= reg_wdata[CCR_B4_FREQ_SEL];
    end
  end
  // bits 4..0: status disable, two hiccup disables, detect force, input ocp enable
  always_ff @(posedge clk_sys) begin
    if (rst || (clk_en && reg_soft_reset)) begin
      four_lo_q <= {4'h0, CCR_RST_IN_OCP_EN};
    end else if (wr_four) begin
      four_lo_q <= reg_wdata[4:0];
    end else if (clk_en && watchdog_expire) begin
      four_lo_q[CCR_B4_STAT_DIS] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control two and ship switch sequencer
  // ---------------------------------------------------------------
  logic skip_q, arm;
  logic [1:0] action_q;
  ccr_ship_state_t ship_state_q;
  logic [31:0] ship_cnt_q;
  assign arm = wr_two && (reg_wdata[2:1] != CCR_ACT_IDLE);
  always_ff @(posedge clk_sys) begin
    if (rst || (clk_en && reg_soft_reset)) begin
      skip_q <= CCR_RST_DELAY_SKIP;
      action_q <= CCR_RST_ACTION;
    end else if (wr_two) begin
      skip_q <= reg_wdata[CCR_B2_DELAY_SKIP];
      action_q <= reg_wdata[2:1];
    end else if (ship_action_fire && clk_en) begin
      // field falls back to idle once the action has been issued
      action_q <= CCR_ACT_IDLE;
    end
  end
  // action code issued to power stage
  always_ff @(posedge clk_sys) begin
    if (rst || (clk_en && reg_soft_reset)) begin
      ship_state_q <= CCR_SHIP_IDLE;
      ship_cnt_q <= 32'h0;
      ship_action_fire <= 1'b0;
      ship_action_code <= CCR_ACT_IDLE;
    end else if (clk_en) begin
      ship_action_fire <= 1'b0;
      if (wr_two && !arm) begin
        // writing idle cancels a pending action
        ship_state_q <= CCR_SHIP_IDLE;
      end else if (arm) begin
        ship_action_code <= reg_wdata[2:1];
        if (reg_wdata[CCR_B2_DELAY_SKIP]) begin
          ship_action_fire <= 1'b1;
          ship_state_q <= CCR_SHIP_IDLE;
        end else begin
          ship_cnt_q <= SHIP_DELAY_CYC - 32'h1;
          ship_state_q <= CCR_SHIP_WAIT;
        end
      end else begin
        unique case (ship_state_q)
          CCR_SHIP_IDLE: ship_cnt_q <= 32'h0;
          CCR_SHIP_WAIT: begin
            if (ship_cnt_q == 32'h0) begin
              ship_action_fire <= 1'b1;
              ship_state_q <= CCR_SHIP_IDLE;
            end else begin
              ship_cnt_q <= ship_cnt_q - 32'h1;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // ship mode wake timer
  // ---------------------------------------------------------------
  logic [31:0] wake_cnt_q, wake_need;
  logic wake_done_q;
  assign wake_need = three_q[CCR_B3_WAKE_SEL] ? WAKE_SHORT_CYC : WAKE_LONG_CYC;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_cnt_q <= 32'h0;
      wake_done_q <= 1'b0;
      ship_wake_req <= 1'b0;
    end else if (clk_en) begin
      ship_wake_req <= 1'b0;
      if (onreq_stable_q) begin
        wake_cnt_q <= 32'h0;
        wake_done_q <= 1'b0;
      end else if (!wake_done_q) begin
        if (wake_cnt_q + 32'h1 >= wake_need) begin
          ship_wake_req <= 1'b1;
          wake_done_q <= 1'b1;
        end else begin
          wake_cnt_q <= wake_cnt_q + 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // unmapped offsets and the out-of-scope upper bits of control two read zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (hit(reg_addr, CCR_OFS_CTRL_TWO)) begin
        reg_rdata <= {5'h00, action_q, skip_q};
      end else if (hit(reg_addr, CCR_OFS_CTRL_THREE)) begin
        reg_rdata <= three_q;
      end else if (hit(reg_addr, CCR_OFS_CTRL_FOUR)) begin
        reg_rdata <= {drv_two_q, drv_one_q, freq_q, four_lo_q};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end
  assign input_driver_master_disable = three_q[CCR_B3_DRV_MASTER_DIS];
  assign reverse_output_enable = three_q[CCR_B3_REV_OUT_EN];
  assign reverse_pulse_freq_disable = three_q[CCR_B3_REV_PFM_DIS];
  assign forward_pulse_freq_disable = three_q[CCR_B3_FWD_PFM_DIS];
  assign ship_wake_pulse_select = three_q[CCR_B3_WAKE_SEL];
  assign batt_switch_linear_disable = three_q[CCR_B3_LIN_DIS];
  assign reverse_out_of_audio_disable = three_q[CCR_B3_REV_OOA_DIS];
  assign forward_out_of_audio_disable = three_q[CCR_B3_FWD_OOA_DIS];
  assign input_gate_driver_two_enable = drv_two_q;
  assign input_gate_driver_one_enable = drv_one_q;
  assign switching_frequency_select = freq_q;
  assign status_pin_disable = four_lo_q[CCR_B4_STAT_DIS];
  assign system_short_hiccup_disable = four_lo_q[CCR_B4_SYS_SHORT_DIS];
  assign reverse_undervoltage_hiccup_disable = four_lo_q[CCR_B4_REV_UV_DIS];

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic ce_wd;
  assign ce_wd = clk_en && watchdog_expire && !reg_soft_reset && !wr_three && !wr_four;
  property p_skip_fires;
    arm && reg_wdata[CCR_B2_DELAY_SKIP] && !reg_soft_reset |=> ship_action_fire;
  endproperty
  a_skip_fires: assert property (p_skip_fires) else $error("skip write did not fire");
  property p_wait_holds;
    arm && !reg_wdata[CCR_B2_DELAY_SKIP] |=> (!ship_action_fire || $past(arm)) [*8];
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("action fired without delay");
  property p_code_matches;
    arm && !reg_soft_reset |=> ship_action_code == $past(reg_wdata[2:1]);
  endproperty
  a_code_matches: assert property (p_code_matches) else $error("wrong action code");
  property p_master_lock;
    input_driver_master_disable |-> !drv_one_q && !drv_two_q;
  endproperty
  a_master_lock: assert property (p_master_lock) else $error("driver on while disabled");
  property p_wd_clear;
    ce_wd |=> !reverse_output_enable && !reverse_pulse_freq_disable && !status_pin_disable
              && !batt_switch_linear_disable && !reverse_out_of_audio_disable;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("watchdog left field set");
  property p_wd_keeps_fwd;
    ce_wd && !wr_four |=> $stable(forward_pulse_freq_disable) && $stable(system_short_hiccup_disable)
                          && $stable(forward_out_of_audio_disable);
  endproperty
  a_wd_keeps_fwd: assert property (p_wd_keeps_fwd) else $error("watchdog hit forward field");
  property p_soft_clears;
    clk_en && reg_soft_reset |=> three_q == CCR_RST_CTRL_THREE && !status_pin_disable;
  endproperty
  a_soft_clears: assert property (p_soft_clears) else $error("register reset incomplete");
  property p_one_absent;
    pair_one_absent_q |-> !drv_one_q;
  endproperty
  a_one_absent: assert property (p_one_absent) else $error("driver one unlocked");
  property p_two_absent;
    pair_two_absent_q |-> !drv_two_q;
  endproperty
  a_two_absent: assert property (p_two_absent) else $error("driver two unlocked");
  property p_strap_load;
    strap_load |=> freq_q == strap_stable_q;
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap not captured");
  property p_wake_len;
    ship_wake_req |-> !$past(onreq_stable_q) && $past(wake_cnt_q) + 32'h1 >= $past(wake_need);
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake too early");
  c_wait_fire: cover property (ship_state_q == CCR_SHIP_WAIT ##1 ship_action_fire);
  c_wake: cover property (ship_wake_req);
  c_lock_write: cover property (wr_four && reg_wdata[CCR_B4_DRV_ONE_EN] && input_driver_master_disable);
endmodule // ccr_bank

//--- verilog/ccr_pkg.sv
// package of offsets, field positions, reset values and timing counts for the control bank
package ccr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CCR_OFS_CTRL_TWO = 8'h11;
  localparam logic [7:0] CCR_OFS_CTRL_THREE = 8'h12;
  localparam logic [7:0] CCR_OFS_CTRL_FOUR = 8'h13;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CCR_B2_DELAY_SKIP = 0;
  localparam int CCR_B2_ACTION_LO = 1;
  localparam int CCR_B3_DRV_MASTER_DIS = 7;
  localparam int CCR_B3_REV_OUT_EN = 6;
  localparam int CCR_B3_REV_PFM_DIS = 5;
  localparam int CCR_B3_FWD_PFM_DIS = 4;
  localparam int CCR_B3_WAKE_SEL = 3;
  localparam int CCR_B3_LIN_DIS = 2;
  localparam int CCR_B3_REV_OOA_DIS = 1;
  localparam int CCR_B3_FWD_OOA_DIS = 0;
  localparam int CCR_B4_DRV_TWO_EN = 7;
  localparam int CCR_B4_DRV_ONE_EN = 6;
  localparam int CCR_B4_FREQ_SEL = 5;
  localparam int CCR_B4_STAT_DIS = 4;
  localparam int CCR_B4_SYS_SHORT_DIS = 3;
  localparam int CCR_B4_REV_UV_DIS = 2;
  localparam int CCR_B4_VIN_DET_FORCE = 1;
  localparam int CCR_B4_IN_OCP_EN = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CCR_RST_CTRL_THREE = 8'h00;
  localparam logic CCR_RST_DELAY_SKIP = 1'b0;
  localparam logic [1:0] CCR_RST_ACTION = 2'h0;
  localparam logic CCR_RST_IN_OCP_EN = 1'b1;

  // ship switch actions
  typedef enum logic [1:0] {
    CCR_ACT_IDLE = 2'b00,
    CCR_ACT_SHUTDOWN = 2'b01,
    CCR_ACT_SHIP = 2'b10,
    CCR_ACT_SYS_RESET = 2'b11
  } ccr_action_t;

  typedef enum logic [0:0] {
    CCR_SHIP_IDLE = 1'b0,
    CCR_SHIP_WAIT = 1'b1
  } ccr_ship_state_t;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CCR_CLK_MHZ = 200;
  localparam int unsigned CCR_SHIP_DELAY_MS = 10000;
  localparam int unsigned CCR_WAKE_LONG_MS = 1000;
  localparam int unsigned CCR_WAKE_SHORT_US = 15000;
  localparam logic [31:0] CCR_SHIP_DELAY_CYC = 32'(CCR_SHIP_DELAY_MS * CCR_CLK_MHZ * 1000);
  localparam logic [31:0] CCR_WAKE_LONG_CYC = 32'(CCR_WAKE_LONG_MS * CCR_CLK_MHZ * 1000);
  localparam logic [31:0] CCR_WAKE_SHORT_CYC = 32'(CCR_WAKE_SHORT_US * CCR_CLK_MHZ);
  localparam logic [1:0] CCR_STRAP_SETTLE_CYC = 2'h3;

endpackage
